/* design/pinsel_pkg.sv */
package pinsel_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] SPF_OFFSET = 12'h000;
  localparam logic [11:0] IRC_OFFSET = 12'h004;
  localparam logic [11:0] STAT_OFFSET = 12'h008;

  // ==========================================================
  // pin control register fields
  localparam int CH2_SEL_BIT = 5;
  localparam int CH1_SEL_BIT = 4;
  localparam int CH2_TXINV_BIT = 3;
  localparam int CH2_RXINV_BIT = 2;
  localparam int CH1_TXINV_BIT = 1;
  localparam int CH1_RXINV_BIT = 0;
  localparam logic [7:0] SPF_RESET = 8'hc0;
  localparam logic [7:0] SPF_ONES = 8'hc0;
  localparam logic [7:0] SPF_WMASK = 8'h3f;

  // ==========================================================
  // infrared control register fields
  localparam int IR_ON_BIT = 7;
  localparam int IR_WIDTH_LSB = 4;
  localparam logic [7:0] IRC_RESET = 8'h00;
  localparam logic [7:0] IRC_WMASK = 8'hf0;

  // ==========================================================
  // status register fields
  localparam int STAT_ENC_BIT = 0;
  localparam int STAT_CH1RX_BIT = 1;
  localparam int STAT_CH2RX_BIT = 2;

  // ==========================================================
  // infrared timing
  localparam logic [2:0] IR_W_3_16 = 3'h0;
  localparam logic [7:0] IR_W_3_16_TICKS = 8'h03;
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [4:0] DEC_TICKS = 5'h10;
  localparam int CLK_MHZ = 20;
  localparam int IR_W1_NS = 200;
  localparam int IR_W2_NS = 400;
  localparam int IR_W3_NS = 800;
  localparam int IR_W4_NS = 1600;
  localparam logic [7:0] IR_W1_CYC = 8'((IR_W1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] IR_W2_CYC = 8'((IR_W2_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] IR_W3_CYC = 8'((IR_W3_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] IR_W4_CYC = 8'((IR_W4_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic {ENC_IDLE = 1'b0, ENC_PULSE = 1'b1} enc_state_t;

endpackage

/* design/ir_codec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ir_codec_if;
  logic enable;
  logic tick16;
  logic tx_bit;
  logic rx_level;
  logic [2:0] width_code;
  logic enc_out;
  logic dec_out;
  modport top(output enable, output tick16, output tx_bit, output rx_level,
              output width_code, input enc_out, input dec_out);
  modport codec(input enable, input tick16, input tx_bit, input rx_level,
                input width_code, output enc_out, output dec_out);
endinterface
`default_nettype wire

/* design/ir_codec.sv */
`timescale 1ns/1ps
`default_nettype none
module ir_codec (
  input wire logic pclk,
  input wire logic presetn,
  ir_codec_if.codec cif
);

  // ==========================================================
  // pulse length per width code; prohibited codes fall back to 3/16
  function automatic logic [7:0] pulse_len(input logic [2:0] code);
    logic [7:0] len;
    len = pinsel_pkg::IR_W_3_16_TICKS;
    case (code)
      3'h1: len = pinsel_pkg::IR_W1_CYC;
      3'h2: len = pinsel_pkg::IR_W2_CYC;
      3'h3: len = pinsel_pkg::IR_W3_CYC;
      3'h4: len = pinsel_pkg::IR_W4_CYC;
      default: len = pinsel_pkg::IR_W_3_16_TICKS;
    endcase
    return len;
  endfunction

  logic use_tick;
  logic step;
  logic bit_start;
  logic tx_prev_reg;
  logic rx_prev_reg;
  logic [3:0] tick_cnt_reg;
  logic [7:0] remain_reg;
  logic [4:0] dec_cnt_reg;
  logic [7:0] help_ticks_reg;
  pinsel_pkg::enc_state_t state_reg;

  assign use_tick = (cif.width_code == pinsel_pkg::IR_W_3_16) || (cif.width_code > 3'h4);
  assign step = use_tick ? cif.tick16 : 1'b1;
  // bit boundary: any transmitter edge resyncs, otherwise every 16 ticks
  assign bit_start = cif.enable &&
    ((cif.tx_bit != tx_prev_reg) || (cif.tick16 && tick_cnt_reg == pinsel_pkg::TICKS_LAST));

  // ==========================================================
  // bit timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_prev_reg <= 1'b1;
      tick_cnt_reg <= 4'h0;
    end else begin
      tx_prev_reg <= cif.tx_bit;
      if (bit_start) begin
        tick_cnt_reg <= 4'h0;
      end else if (cif.tick16) begin
        tick_cnt_reg <= tick_cnt_reg + 4'h1;
      end
    end
  end

  // ==========================================================
  // encoder: one high pulse per zero bit, low for one bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= pinsel_pkg::ENC_IDLE;
      remain_reg <= 8'h00;
    end else if (!cif.enable) begin
      state_reg <= pinsel_pkg::ENC_IDLE;
      remain_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        pinsel_pkg::ENC_IDLE: begin
          if (bit_start && !cif.tx_bit) begin // R15
            state_reg <= pinsel_pkg::ENC_PULSE;
            remain_reg <= pulse_len(cif.width_code); // R13
          end
        end
        pinsel_pkg::ENC_PULSE: begin
          if (step) begin
            remain_reg <= remain_reg - 8'h01;
            if (remain_reg == 8'h01) begin
              state_reg <= pinsel_pkg::ENC_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign cif.enc_out = (state_reg == pinsel_pkg::ENC_PULSE);

  // ==========================================================
  // decoder: a received pulse reads as a zero bit for one bit time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_reg <= 1'b0;
      dec_cnt_reg <= 5'h00;
    end else begin
      rx_prev_reg <= cif.rx_level;
      if (!cif.enable) begin
        dec_cnt_reg <= 5'h00;
      end else if (cif.rx_level && !rx_prev_reg) begin
        dec_cnt_reg <= pinsel_pkg::DEC_TICKS; // R15
      end else if (cif.tick16 && dec_cnt_reg != 5'h00) begin
        dec_cnt_reg <= dec_cnt_reg - 5'h01;
      end
    end
  end

  assign cif.dec_out = (dec_cnt_reg == 5'h00);

  // ==========================================================
  // checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      help_ticks_reg <= 8'h00;
    end else if (state_reg == pinsel_pkg::ENC_IDLE) begin
      help_ticks_reg <= 8'h00;
    end else if (cif.tick16) begin
      help_ticks_reg <= help_ticks_reg + 8'h01;
    end
  end

  AST_ENC_316_WIDTH: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (state_reg == pinsel_pkg::ENC_PULSE && cif.width_code == pinsel_pkg::IR_W_3_16 &&
     cif.tick16 && remain_reg == 8'h01) |-> help_ticks_reg == 8'h02)
    else $error("3/16 pulse is not three ticks wide");

  AST_ENC_ZERO_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (state_reg == pinsel_pkg::ENC_IDLE && bit_start && !cif.tx_bit) |=> cif.enc_out)
    else $error("zero bit did not start a pulse");

  AST_ENC_ONE_LOW: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (state_reg == pinsel_pkg::ENC_IDLE && cif.tx_bit) |=> !cif.enc_out)
    else $error("one bit produced a pulse");

  AST_DEC_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (cif.enable && cif.rx_level && !rx_prev_reg) |=> !cif.dec_out [*2])
    else $error("received pulse not decoded as zero");

  COV_ENC_PULSE: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(cif.enc_out));

endmodule
`default_nettype wire

/* design/serial_pin_select_ir_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - pin control bits 7:6 always read 1, writes ignored
// R2 - bit 5 routes shared pin A to channel 2 transmit, else port
// R3 - software enables channel 2 transmit only after selecting its pin
// R4 - bit 4 routes shared pin B to channel 1 transmit, else port
// R5 - software enables channel 1 transmit only after selecting its pin
// R6 - bit 3 inverts channel 2 transmit pin data
// R7 - bit 2 inverts channel 2 receive pin data
// R8 - bit 1 inverts channel 1 transmit pin data
// R9 - bit 0 inverts channel 1 receive pin data
// R10 - inversion changes apply immediately and may glitch a live line
// R11 - software changes pin control only while the line is idle
// R12 - infrared bit 7 routes channel 1 through the infrared codec
// R13 - width field 6:4 sets pulse width, 000 is 3/16 bit
// R14 - infrared control bits 3:0 read 0, writes ignored
// R15 - encoder pulses for zero bits, decoder maps pulses back to zero
module serial_pin_select_ir_ctl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial engines
  input wire logic ch1_tx_data,
  input wire logic ch2_tx_data,
  input wire logic ch1_tick16,
  output logic ch1_rx_data,
  output logic ch2_rx_data,
  // general port side of the shared pins
  input wire logic gpio_a_out,
  input wire logic gpio_a_oe,
  input wire logic gpio_b_out,
  input wire logic gpio_b_oe,
  output logic gpio_a_in,
  output logic gpio_b_in,
  // shared pin a (port or channel 2 serial out)
  input wire logic port_pin_a_in,
  output logic port_pin_a_out,
  output logic port_pin_a_oe,
  // shared pin b (port or channel 1 serial out / infrared out)
  input wire logic port_pin_b_in,
  output logic port_pin_b_out,
  output logic port_pin_b_oe,
  // receive pins
  input wire logic ch1_serial_in,
  input wire logic ch2_serial_in
);

  // ==========================================================
  // shared-pin data: serial function with polarity, or port data
  function automatic logic pin_data(input logic sel, input logic inv,
                                    input logic tx, input logic gpio);
    return sel ? (tx ^ inv) : gpio;
  endfunction

  logic [7:0] spf_reg;
  logic [7:0] irc_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic setup;
  logic access;
  logic mapped;
  logic [7:0] rd_value;
  logic ir_on;
  logic ch1_tx_eff;
  logic ch1_rx_pin;
  logic ch2_rx_pin;
  logic pin_a_out_reg;
  logic pin_a_oe_reg;
  logic pin_b_out_reg;
  logic pin_b_oe_reg;
  logic ch1_rx_reg;
  logic ch2_rx_reg;
  logic gpio_a_in_reg;
  logic gpio_b_in_reg;

  ir_codec_if cif ();

  // ==========================================================
  // apb decode
  assign setup = psel && !penable;
  assign access = psel && penable && pready_reg;
  assign mapped = (paddr == pinsel_pkg::SPF_OFFSET) || (paddr == pinsel_pkg::IRC_OFFSET) ||
                  (paddr == pinsel_pkg::STAT_OFFSET);

  always_comb begin
    rd_value = 8'h00;
    if (paddr == pinsel_pkg::SPF_OFFSET) begin
      rd_value = spf_reg | pinsel_pkg::SPF_ONES; // R1
    end else if (paddr == pinsel_pkg::IRC_OFFSET) begin
      rd_value = irc_reg & pinsel_pkg::IRC_WMASK; // R14
    end else if (paddr == pinsel_pkg::STAT_OFFSET) begin
      rd_value[pinsel_pkg::STAT_ENC_BIT] = cif.enc_out;
      rd_value[pinsel_pkg::STAT_CH1RX_BIT] = ch1_rx_reg;
      rd_value[pinsel_pkg::STAT_CH2RX_BIT] = ch2_rx_reg;
    end
  end

  // one wait-free access phase: answer is prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata_reg <= {24'h00_0000, rd_value};
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spf_reg <= pinsel_pkg::SPF_RESET;
    end else if (access && pwrite && pstrb[0] && paddr == pinsel_pkg::SPF_OFFSET) begin
      spf_reg <= (pwdata[7:0] & pinsel_pkg::SPF_WMASK) | pinsel_pkg::SPF_ONES; // R1 R10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irc_reg <= pinsel_pkg::IRC_RESET;
    end else if (access && pwrite && pstrb[0] && paddr == pinsel_pkg::IRC_OFFSET) begin
      irc_reg <= pwdata[7:0] & pinsel_pkg::IRC_WMASK; // R14
    end
  end

  // ==========================================================
  // infrared codec on channel 1
  assign ir_on = irc_reg[pinsel_pkg::IR_ON_BIT];
  assign ch1_rx_pin = ch1_serial_in ^ spf_reg[pinsel_pkg::CH1_RXINV_BIT]; // R9
  assign ch2_rx_pin = ch2_serial_in ^ spf_reg[pinsel_pkg::CH2_RXINV_BIT]; // R7
  assign cif.enable = ir_on; // R12
  assign cif.tick16 = ch1_tick16;
  assign cif.tx_bit = ch1_tx_data;
  assign cif.rx_level = ch1_rx_pin;
  assign cif.width_code = irc_reg[pinsel_pkg::IR_WIDTH_LSB +: 3]; // R13
  assign ch1_tx_eff = ir_on ? cif.enc_out : ch1_tx_data; // R12

  ir_codec u_codec (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif)
  );

  // ==========================================================
  // pin paths; a polarity write shows on the pin at the next edge, so a
  // write during a live frame glitches the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_out_reg <= 1'b0;
      pin_a_oe_reg <= 1'b0;
      ch2_rx_reg <= 1'b1;
      gpio_a_in_reg <= 1'b0;
    end else begin
      pin_a_out_reg <= pin_data(spf_reg[pinsel_pkg::CH2_SEL_BIT],
                                spf_reg[pinsel_pkg::CH2_TXINV_BIT],
                                ch2_tx_data, gpio_a_out); // R2 R6 R10
      pin_a_oe_reg <= spf_reg[pinsel_pkg::CH2_SEL_BIT] ? 1'b1 : gpio_a_oe; // R2
      ch2_rx_reg <= ch2_rx_pin; // R7
      gpio_a_in_reg <= port_pin_a_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_b_out_reg <= 1'b0;
      pin_b_oe_reg <= 1'b0;
      ch1_rx_reg <= 1'b1;
      gpio_b_in_reg <= 1'b0;
    end else begin
      pin_b_out_reg <= pin_data(spf_reg[pinsel_pkg::CH1_SEL_BIT],
                                spf_reg[pinsel_pkg::CH1_TXINV_BIT],
                                ch1_tx_eff, gpio_b_out); // R4 R8 R10
      pin_b_oe_reg <= spf_reg[pinsel_pkg::CH1_SEL_BIT] ? 1'b1 : gpio_b_oe; // R4
      ch1_rx_reg <= ir_on ? cif.dec_out : ch1_rx_pin; // R9 R12
      gpio_b_in_reg <= port_pin_b_in;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign port_pin_a_out = pin_a_out_reg;
  assign port_pin_a_oe = pin_a_oe_reg;
  assign port_pin_b_out = pin_b_out_reg;
  assign port_pin_b_oe = pin_b_oe_reg;
  assign ch1_rx_data = ch1_rx_reg;
  assign ch2_rx_data = ch2_rx_reg;
  assign gpio_a_in = gpio_a_in_reg;
  assign gpio_b_in = gpio_b_in_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SPF_RSV_ONES: assert property ( // R1
    (setup && !pwrite && paddr == pinsel_pkg::SPF_OFFSET) |=> prdata[7:6] == 2'b11)
    else $error("pin control reserved bits not read as one");

  AST_IRC_RSV_ZERO: assert property ( // R14
    (setup && !pwrite && paddr == pinsel_pkg::IRC_OFFSET) |=> prdata[3:0] == 4'h0)
    else $error("infrared reserved bits not read as zero");

  AST_SPF_WRITE: assert property ( // R10
    (access && pwrite && pstrb[0] && paddr == pinsel_pkg::SPF_OFFSET)
    |=> spf_reg[5:0] == $past(pwdata[5:0]) && spf_reg[7:6] == 2'b11)
    else $error("pin control write not applied");

  AST_CH2_SERIAL: assert property ( // R2 R6
    spf_reg[pinsel_pkg::CH2_SEL_BIT] |=> port_pin_a_oe &&
    port_pin_a_out == ($past(ch2_tx_data) ^ $past(spf_reg[pinsel_pkg::CH2_TXINV_BIT])))
    else $error("channel 2 transmit pin wrong");

  AST_CH2_PORT: assert property ( // R2
    !spf_reg[pinsel_pkg::CH2_SEL_BIT]
    |=> port_pin_a_out == $past(gpio_a_out) && port_pin_a_oe == $past(gpio_a_oe))
    else $error("pin a not following port data");

  AST_CH1_SERIAL: assert property ( // R4 R8
    (spf_reg[pinsel_pkg::CH1_SEL_BIT] && !ir_on) |=> port_pin_b_oe &&
    port_pin_b_out == ($past(ch1_tx_data) ^ $past(spf_reg[pinsel_pkg::CH1_TXINV_BIT])))
    else $error("channel 1 transmit pin wrong");

  AST_CH1_PORT: assert property ( // R4
    !spf_reg[pinsel_pkg::CH1_SEL_BIT]
    |=> port_pin_b_out == $past(gpio_b_out) && port_pin_b_oe == $past(gpio_b_oe))
    else $error("pin b not following port data");

  AST_CH2_RX_POL: assert property ( // R7
    1'b1 |=> ch2_rx_data == ($past(ch2_serial_in) ^ $past(spf_reg[pinsel_pkg::CH2_RXINV_BIT])))
    else $error("channel 2 receive polarity wrong");

  AST_CH1_RX_POL: assert property ( // R9
    !ir_on |=> ch1_rx_data == ($past(ch1_serial_in) ^ $past(spf_reg[pinsel_pkg::CH1_RXINV_BIT])))
    else $error("channel 1 receive polarity wrong");

  AST_IR_ROUTE: assert property ( // R12
    (ir_on && spf_reg[pinsel_pkg::CH1_SEL_BIT]) |=> ch1_rx_data == $past(cif.dec_out) &&
    port_pin_b_out == ($past(cif.enc_out) ^ $past(spf_reg[pinsel_pkg::CH1_TXINV_BIT])))
    else $error("infrared routing wrong");

  // ==========================================================
  // register bus and infrared gating checks
  AST_SPF_READ: assert property ( // R2 R4
    (setup && !pwrite && paddr == pinsel_pkg::SPF_OFFSET)
    |=> prdata[5:0] == $past(spf_reg[5:0]))
    else $error("pin control read data wrong");

  AST_IRC_READ: assert property ( // R12 R13
    (setup && !pwrite && paddr == pinsel_pkg::IRC_OFFSET)
    |=> prdata[7:4] == $past(irc_reg[7:4]))
    else $error("infrared control read data wrong");

  AST_IRC_WRITE: assert property ( // R12 R13 R14
    (access && pwrite && pstrb[0] && paddr == pinsel_pkg::IRC_OFFSET)
    |=> irc_reg == ($past(pwdata[7:0]) & pinsel_pkg::IRC_WMASK))
    else $error("infrared control write not applied");

  // byte 0 strobe off, or any other offset: both registers keep their value
  AST_WRITE_IGNORED: assert property ( // R1 R14
    (access && pwrite && (!pstrb[0] || (paddr != pinsel_pkg::SPF_OFFSET &&
     paddr != pinsel_pkg::IRC_OFFSET))) |=> $stable(spf_reg) && $stable(irc_reg))
    else $error("ignored write changed a register");

  AST_STAT_READ: assert property ( // R7 R9
    (setup && !pwrite && paddr == pinsel_pkg::STAT_OFFSET)
    |=> prdata[2:0] == $past({ch2_rx_reg, ch1_rx_reg, cif.enc_out}))
    else $error("status read data wrong");

  AST_IR_OFF_ENC: assert property ( // R12
    !ir_on |=> !cif.enc_out)
    else $error("encoder active with infrared off");

  AST_IR_OFF_DEC: assert property ( // R12
    !ir_on |=> cif.dec_out)
    else $error("decoder active with infrared off");

  AST_IR_PIN_OE: assert property ( // R4 R12
    (ir_on && spf_reg[pinsel_pkg::CH1_SEL_BIT]) |=> port_pin_b_oe)
    else $error("infrared pin not driven");

  COV_SPF_WRITE: cover property (access && pwrite && paddr == pinsel_pkg::SPF_OFFSET);
  COV_UNMAPPED: cover property (access && pslverr);
  COV_IR_ON_SERIAL: cover property (ir_on && spf_reg[pinsel_pkg::CH1_SEL_BIT] && cif.enc_out);

endmodule
`default_nettype wire

/* tb/line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// far side of the shared pins and receive lines
module line_partner (
  // device pin drive
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  // levels of the other parties on the line
  input wire logic a_ext,
  input wire logic b_ext,
  input wire logic rx1_lvl,
  input wire logic rx2_lvl,
  // resolved wire levels
  output logic a_wire,
  output logic b_wire,
  output logic rx1_wire,
  output logic rx2_wire
);
  // the outside party yields a shared pin whenever the device enables its driver
  assign a_wire = a_oe ? a_out : a_ext;
  assign b_wire = b_oe ? b_out : b_ext;
  // transceiver output; plain serial idles high, infrared idles low
  assign rx1_wire = rx1_lvl;
  assign rx2_wire = rx2_lvl;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ====
  // signals
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, ch1_rx_data, ch2_rx_data, gpio_a_in, gpio_b_in;
  logic ch1_tx_data = 1, ch2_tx_data = 1, ch1_tick16 = 0;
  logic gpio_a_out = 0, gpio_a_oe = 0, gpio_b_out = 0, gpio_b_oe = 0;
  logic a_ext = 1, b_ext = 1, rx1_lvl = 1, rx2_lvl = 1;
  logic pa_w, pb_w, rx1_w, rx2_w, pa_out, pa_oe, pb_out, pb_oe;
  logic [31:0] rd;
  logic er;
  int bad_count = 0, num_checks = 0, cycles = 0, tdiv = 0;
  int spf_m, irc_m, d, c;

  serial_pin_select_ir_ctl serial_pin_select_ir_ctl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch1_tx_data(ch1_tx_data), .ch2_tx_data(ch2_tx_data), .ch1_tick16(ch1_tick16),
    .ch1_rx_data(ch1_rx_data), .ch2_rx_data(ch2_rx_data), .gpio_a_out(gpio_a_out),
    .gpio_a_oe(gpio_a_oe), .gpio_b_out(gpio_b_out), .gpio_b_oe(gpio_b_oe),
    .gpio_a_in(gpio_a_in), .gpio_b_in(gpio_b_in), .port_pin_a_in(pa_w),
    .port_pin_a_out(pa_out), .port_pin_a_oe(pa_oe), .port_pin_b_in(pb_w),
    .port_pin_b_out(pb_out), .port_pin_b_oe(pb_oe), .ch1_serial_in(rx1_w),
    .ch2_serial_in(rx2_w));

  line_partner line_partner_i (.a_out(pa_out), .a_oe(pa_oe), .b_out(pb_out),
    .b_oe(pb_oe), .a_ext(a_ext), .b_ext(b_ext), .rx1_lvl(rx1_lvl), .rx2_lvl(rx2_lvl),
    .a_wire(pa_w), .b_wire(pb_w), .rx1_wire(rx1_w), .rx2_wire(rx2_w));

  // ====
  // clock, baud ticks every 4 cycles, watchdog
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    tdiv <= (tdiv + 1) % 4;
    ch1_tick16 <= (tdiv == 3);
    if (cycles == 10000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ====
  // checking and bus tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] dv, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dv;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wreg(input logic [11:0] a, input int dv);
    apb(1, a, dv, 4'hf);
    if (a == pinsel_pkg::SPF_OFFSET)
      spf_m = (dv & 32'h3f) | 32'hc0;
    else
      irc_m = dv & 32'hf0;
  endtask

  task rreg(input logic [11:0] a, input int exp);
    apb(0, a, 32'h0, 4'hf);
    check(rd, exp);
    check(er, 0);
  endtask

  // ====
  // pin paths with random traffic, plain serial mode
  task pins;
    int i;
    logic pa, pb;
    // line is idle while the register changes
    ch1_tx_data <= 1;
    ch2_tx_data <= 1;
    wreg(pinsel_pkg::SPF_OFFSET, $urandom);
    @(posedge pclk);
    #1;
    check(pa_out, spf_m[5] ? ch2_tx_data ^ spf_m[3] : gpio_a_out);
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      {gpio_a_out, gpio_a_oe, gpio_b_out, gpio_b_oe, a_ext, b_ext, rx1_lvl, rx2_lvl} <=
        8'($urandom);
      // transmit only once the pin is selected
      ch1_tx_data <= spf_m[4] ? 1'($urandom) : 1'b1;
      ch2_tx_data <= spf_m[5] ? 1'($urandom) : 1'b1;
      @(posedge pclk);
      pa = pa_w;
      pb = pb_w;
      #1;
      check(pa_out, spf_m[5] ? ch2_tx_data ^ spf_m[3] : gpio_a_out);
      check(pa_oe, spf_m[5] | gpio_a_oe);
      check(pb_out, spf_m[4] ? ch1_tx_data ^ spf_m[1] : gpio_b_out);
      check(pb_oe, spf_m[4] | gpio_b_oe);
      check(ch1_rx_data, rx1_lvl ^ spf_m[0]);
      check(ch2_rx_data, rx2_lvl ^ spf_m[2]);
      check({gpio_a_in, gpio_b_in}, {pa, pb});
    end
  endtask

  // ====
  // one zero bit then one one bit; counts high cycles on pin b
  task ir_zero(input int spf, input int code, input int exp, input int tol);
    int hi, i;
    wreg(pinsel_pkg::SPF_OFFSET, spf);
    wreg(pinsel_pkg::IRC_OFFSET, 32'h80 | (code << 4));
    do @(posedge pclk); while (tdiv != 3);
    ch1_tx_data <= 0;
    hi = 0;
    for (i = 0; i < 128; i++) begin
      @(posedge pclk);
      hi += pb_out;
      if (i == 63)
        ch1_tx_data <= 1;
    end
    check(hi >= exp - tol && hi <= exp + tol, 1);
  endtask

  initial begin
    void'($urandom(72));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    spf_m = 32'hc0;
    irc_m = 0;
    rreg(pinsel_pkg::SPF_OFFSET, spf_m);
    rreg(pinsel_pkg::IRC_OFFSET, irc_m);
    repeat (8) begin
      wreg(pinsel_pkg::SPF_OFFSET, $urandom);
      rreg(pinsel_pkg::SPF_OFFSET, spf_m);
      // width field kept to the permitted codes 000 to 100
      d = ($urandom & 32'hffffff8f) | (($urandom % 5) << 4);
      wreg(pinsel_pkg::IRC_OFFSET, d);
      rreg(pinsel_pkg::IRC_OFFSET, irc_m);
    end
    apb(1, pinsel_pkg::SPF_OFFSET, 32'h3f, 4'h0);
    rreg(pinsel_pkg::SPF_OFFSET, spf_m);
    apb(0, 12'h00c, 32'h0, 4'hf);
    check(er, 1);
    wreg(pinsel_pkg::IRC_OFFSET, 0);
    repeat (40) pins();
    ch1_tx_data <= 1;
    // 16 ticks of 4 cycles per bit: 3/16 is 12 cycles, wider codes double from 200 ns
    ir_zero(32'h10, 0, 12, 0);
    for (c = 1; c < 5; c++)
      ir_zero(32'h10, c, 4 << (c - 1), 0);
    ir_zero(32'h12, 0, 116, 0);
    for (c = 0; c < 2; c++) begin
      wreg(pinsel_pkg::SPF_OFFSET, 32'h10 | c);
      rx1_lvl <= c[0];
      repeat (80) @(posedge pclk);
      rx1_lvl <= !c[0];
      d = 0;
      repeat (112) begin
        @(posedge pclk);
        d += !ch1_rx_data;
        if (d == 12)
          rx1_lvl <= c[0];
      end
      check(d >= 60 && d <= 68, 1);
    end
    rreg(pinsel_pkg::STAT_OFFSET, {rx2_lvl ^ spf_m[2], 2'b10});
    wrap_up();
  end
endmodule
`default_nettype wire
